// File: logic/rgb_dim_consts.svh
// Constants for the three-channel LED command decoder and dimming engine
`ifndef RGB_DIM_CONSTS_SVH
`define RGB_DIM_CONSTS_SVH

// ************************************************************
// Bus framing
// ************************************************************
`define DEV_ADDR_WR     8'h72
`define SEL_MSB         7
`define SEL_LSB         5
`define PAY_MSB         4
`define PAY_LSB         0
`define BITS_PER_BYTE   4'h8

// ************************************************************
// Timing
// ************************************************************
`define CLK_HZ          20000000
`define TICK_HZ         1000000
`define TICK_DIV        (`CLK_HZ / `TICK_HZ)
`define STEP_UNIT_MS    8
`define STEP_UNIT_TICKS (`STEP_UNIT_MS * (`TICK_HZ / 1000))
`define PWM_PRESC       15

// ************************************************************
// Codes and reset values
// ************************************************************
`define DUTY_FULL       5'h1F
`define CODE_MAX        5'h1F
`define CODE_TOP_SHARED 5'h1E
`define CODE_RST        5'h00
`define DUTY_RST        5'h00
`define TARGET_RST      5'h00
`define TIME_RST        5'h00

`endif

// File: logic/rgb_dim_pkg.sv
// Types shared by the LED command decoder files
package rgb_dim_pkg;

  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK_A = 6'h04,
    ST_DATA  = 6'h08,
    ST_ACK_D = 6'h10,
    ST_SKIP  = 6'h20
  } rx_state_t;

  typedef enum logic [2:0]
  {
    SEL_SHUTDOWN = 3'h0,
    SEL_PEAK     = 3'h1,
    SEL_DUTY1    = 3'h2,
    SEL_DUTY2    = 3'h3,
    SEL_DUTY3    = 3'h4,
    SEL_UP_TGT   = 3'h5,
    SEL_DN_TGT   = 3'h6,
    SEL_TIME_RUN = 3'h7
  } sel_t;

endpackage : rgb_dim_pkg

// File: logic/rgb_duty_mod.sv
// One duty-cycle modulator channel
`timescale 1ns/10ps
`include "rgb_dim_consts.svh"

module rgb_duty_mod
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic [4:0] i_duty,
  input  wire logic [4:0] i_phase,
  output logic            o_on
);

  // ************************************************************
  // Modulator
  // ************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_on <= 1'b0;
    else
      o_on <= (i_duty == `DUTY_FULL) || (i_phase < i_duty);
  end

  a_duty_extremes : assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_duty == 5'h00 |=> !o_on) and (i_duty == `DUTY_FULL |=> o_on))
    else $error("duty extreme not honoured");

endmodule : rgb_duty_mod

// File: logic/rgb_dim_core.sv
// Write-only two-wire target, command decoder and gradual dimming engine
// Summary of operation
// - Answer only to 7-bit address 0x39; other addresses are ignored.
// - Only write frames accepted; first byte 0x72, reads not acknowledged.
// - A frame is address plus exactly one command byte; extra bytes ignored.
// - Command bits 7..5 select the function, bits 4..0 are payload.
// - Selector 000 shuts down: all LED current zero, payload ignored.
// - Selector 001 sets common peak step, weights 16..1, no dimming.
// - Selectors 010, 011, 100 load duty for outputs one, two, three.
// - Selectors 101 and 110 store upward and downward dimming targets.
// - Selector 111 stores time per step in 8 ms units and starts dimming.
// - Run length is step time times step count, by repeated timing.
// - Step n gives current proportional to 1/(31-n); 30 and 31 equal.
// - Step code zero forces output current to zero.
// - Pump off above 5.7 V, back on below 4.4 V, no latch.
// - Without dimming, a step write takes effect at its acknowledge.
// - Step count is absolute difference of present and target step.
// - Dimming starts when the triggering byte is acknowledged.
// - Duty 0 is off, 1F fully on, else 32-step on/off ratio.
`timescale 1ns/10ps
`include "rgb_dim_consts.svh"

module rgb_dim_core
#(
  parameter int P_UNIT_TICKS = `STEP_UNIT_TICKS
)
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_ov_above,
  input  wire logic       i_ov_below,
  output logic            o_pump_en,
  output logic [2:0]      o_led_on,
  output logic [4:0]      o_current_code,
  output logic [4:0]      o_mirror_div,
  output logic            o_dim_busy
);

  localparam logic [4:0]  TICK_LAST  = 5'(`TICK_DIV - 1);
  localparam logic [3:0]  PRESC_LAST = 4'(`PWM_PRESC - 1);
  localparam logic [12:0] UNIT_LAST  = 13'(P_UNIT_TICKS - 1);

  // Divisor of the current mirror; zero means no current
  function automatic logic [4:0] mirror_div(input logic [4:0] code);
    if (code == `CODE_RST)
      mirror_div = 5'h00;
    else if (code >= `CODE_TOP_SHARED)
      mirror_div = 5'h01;
    else
      mirror_div = 5'h1F - code;
  endfunction : mirror_div

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] ova_q;
  logic [1:0] ovb_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      ova_q <= 2'h0;
      ovb_q <= 2'h0;
    end
    else
    begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
      ova_q <= {ova_q[0], i_ov_above};
      ovb_q <= {ovb_q[0], i_ov_below};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl_q[1] & ~scl_q[2];
  assign scl_fall   = ~scl_q[1] & scl_q[2];
  assign start_cond = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_cond  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // ************************************************************
  // Receiver state machine
  // ************************************************************
  rgb_dim_pkg::rx_state_t state_q;
  logic [3:0]             bit_cnt_q;
  logic [7:0]             shift_q;
  logic [7:0]             cmd_q;
  logic                   cmd_stb_q;
  logic                   sda_oe_q;
  logic                   byte_done;
  logic                   addr_hit;

  assign byte_done = scl_fall && (bit_cnt_q == `BITS_PER_BYTE);
  assign addr_hit  = (shift_q == `DEV_ADDR_WR);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      state_q   <= rgb_dim_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      sda_oe_q  <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_q  <= rgb_dim_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (start_cond)
    begin
      state_q   <= rgb_dim_pkg::ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end
    else
    begin
      if (scl_rise && (state_q == rgb_dim_pkg::ST_ADDR || state_q == rgb_dim_pkg::ST_DATA))
      begin
        shift_q   <= {shift_q[6:0], sda_q[1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      case (state_q)
        rgb_dim_pkg::ST_IDLE:
          state_q <= rgb_dim_pkg::ST_IDLE;
        rgb_dim_pkg::ST_ADDR:
          if (byte_done)
          begin
            // Reads and foreign addresses get no acknowledge
            state_q  <= addr_hit ? rgb_dim_pkg::ST_ACK_A : rgb_dim_pkg::ST_SKIP;
            sda_oe_q <= addr_hit;
          end
        rgb_dim_pkg::ST_ACK_A:
          if (scl_fall)
          begin
            state_q   <= rgb_dim_pkg::ST_DATA;
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
          end
        rgb_dim_pkg::ST_DATA:
          if (byte_done)
          begin
            state_q  <= rgb_dim_pkg::ST_ACK_D;
            sda_oe_q <= 1'b1;
          end
        rgb_dim_pkg::ST_ACK_D:
          if (scl_fall)
          begin
            state_q  <= rgb_dim_pkg::ST_SKIP;
            sda_oe_q <= 1'b0;
          end
        rgb_dim_pkg::ST_SKIP:
          state_q <= rgb_dim_pkg::ST_SKIP;
        default:
        begin
          state_q  <= rgb_dim_pkg::ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Command fires on the clock edge on which the master samples our acknowledge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      cmd_q     <= 8'h00;
      cmd_stb_q <= 1'b0;
    end
    else
    begin
      cmd_stb_q <= scl_rise && (state_q == rgb_dim_pkg::ST_ACK_D);
      if (byte_done && state_q == rgb_dim_pkg::ST_DATA)
        cmd_q <= shift_q;
    end
  end

  rgb_dim_pkg::sel_t sel;
  logic [4:0]        payload;

  assign sel     = rgb_dim_pkg::sel_t'(cmd_q[`SEL_MSB:`SEL_LSB]);
  assign payload = cmd_q[`PAY_MSB:`PAY_LSB];

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [4:0] duty_q [3];
  logic [4:0] up_tgt_q;
  logic [4:0] dn_tgt_q;
  logic       dir_up_q;
  logic [4:0] time_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      duty_q[0] <= `DUTY_RST;
      duty_q[1] <= `DUTY_RST;
      duty_q[2] <= `DUTY_RST;
    end
    else if (cmd_stb_q)
    begin
      if (sel == rgb_dim_pkg::SEL_DUTY1)
        duty_q[0] <= payload;
      if (sel == rgb_dim_pkg::SEL_DUTY2)
        duty_q[1] <= payload;
      if (sel == rgb_dim_pkg::SEL_DUTY3)
        duty_q[2] <= payload;
    end
  end

  // Last target written picks the direction of the next run
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      up_tgt_q <= `TARGET_RST;
      dn_tgt_q <= `TARGET_RST;
      dir_up_q <= 1'b1;
      time_q   <= `TIME_RST;
    end
    else if (cmd_stb_q)
    begin
      if (sel == rgb_dim_pkg::SEL_UP_TGT)
      begin
        up_tgt_q <= payload;
        dir_up_q <= 1'b1;
      end
      if (sel == rgb_dim_pkg::SEL_DN_TGT)
      begin
        dn_tgt_q <= payload;
        dir_up_q <= 1'b0;
      end
      if (sel == rgb_dim_pkg::SEL_TIME_RUN)
        time_q <= payload;
    end
  end

  // ************************************************************
  // Timebase and step timing
  // ************************************************************
  logic [4:0]  tick_cnt_q;
  logic        tick;
  logic [12:0] unit_cnt_q;
  logic [4:0]  mult_cnt_q;
  logic        run_q;
  logic        step_due;
  logic        run_cmd;

  assign tick     = (tick_cnt_q == TICK_LAST);
  assign run_cmd  = cmd_stb_q && (sel == rgb_dim_pkg::SEL_TIME_RUN);
  // Zero time still advances once per 8 ms unit rather than stalling
  assign step_due = run_q && tick && (unit_cnt_q == UNIT_LAST) &&
                    (({1'b0, mult_cnt_q} + 6'h01) >= {1'b0, time_q});

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      tick_cnt_q <= 5'h00;
    else
      tick_cnt_q <= tick ? 5'h00 : tick_cnt_q + 5'h01;
  end

  // Restarting the unit count makes every run start with a full step
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn || run_cmd || !run_q)
    begin
      unit_cnt_q <= 13'h0000;
      mult_cnt_q <= 5'h00;
    end
    else if (tick)
    begin
      if (unit_cnt_q == UNIT_LAST)
      begin
        unit_cnt_q <= 13'h0000;
        mult_cnt_q <= step_due ? 5'h00 : mult_cnt_q + 5'h01;
      end
      else
        unit_cnt_q <= unit_cnt_q + 13'h0001;
    end
  end

  // ************************************************************
  // Present step position and dimming run
  // ************************************************************
  logic [4:0] cur_q;
  logic [4:0] rem_q;
  logic [4:0] tgt;
  logic [4:0] diff;

  assign tgt  = dir_up_q ? up_tgt_q : dn_tgt_q;
  assign diff = (cur_q > tgt) ? cur_q - tgt : tgt - cur_q;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      cur_q <= `CODE_RST;
      rem_q <= 5'h00;
      run_q <= 1'b0;
    end
    else if (cmd_stb_q && sel == rgb_dim_pkg::SEL_SHUTDOWN)
    begin
      cur_q <= `CODE_RST;
      run_q <= 1'b0;
      rem_q <= 5'h00;
    end
    else if (cmd_stb_q && sel == rgb_dim_pkg::SEL_PEAK)
    begin
      cur_q <= payload;
      run_q <= 1'b0;
      rem_q <= 5'h00;
    end
    else if (run_cmd)
    begin
      rem_q <= diff;
      run_q <= (diff != 5'h00);
    end
    else if (step_due)
    begin
      cur_q <= (cur_q < tgt) ? cur_q + 5'h01 : cur_q - 5'h01;
      rem_q <= rem_q - 5'h01;
      run_q <= (rem_q != 5'h01);
    end
  end

  // ************************************************************
  // Duty modulation
  // ************************************************************
  logic [3:0] presc_q;
  logic [4:0] phase_q;

  // 1 MHz / (15 * 32) gives a frame near 2.1 kHz
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      presc_q <= 4'h0;
      phase_q <= 5'h00;
    end
    else if (tick)
    begin
      presc_q <= (presc_q == PRESC_LAST) ? 4'h0 : presc_q + 4'h1;
      if (presc_q == PRESC_LAST)
        phase_q <= phase_q + 5'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_duty
      rgb_duty_mod u_mod
      (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_duty    (duty_q[g]),
        .i_phase   (phase_q),
        .o_on      (o_led_on[g])
      );
    end
  endgenerate

  // ************************************************************
  // Outputs and pump gating
  // ************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_sda          <= 1'b0;
      o_current_code <= `CODE_RST;
      o_mirror_div   <= 5'h00;
      o_dim_busy     <= 1'b0;
    end
    else
    begin
      o_sda          <= 1'b0;
      o_current_code <= cur_q;
      o_mirror_div   <= mirror_div(cur_q);
      o_dim_busy     <= run_q;
    end
  end

  assign o_sda_oe = sda_oe_q;

  // Between the thresholds the pump keeps its previous state
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_pump_en <= 1'b1;
    else if (ova_q[1])
      o_pump_en <= 1'b0;
    else if (ovb_q[1])
      o_pump_en <= 1'b1;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence addr_byte_seen;
    state_q == rgb_dim_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence cmd_taken(rgb_dim_pkg::sel_t s);
    cmd_stb_q && sel == s;
  endsequence

  a_addr_ack : assert property (addr_byte_seen and addr_hit |=> o_sda_oe)
    else $error("own address not acknowledged");
  a_foreign_quiet : assert property (addr_byte_seen and !addr_hit |=> !o_sda_oe [*2])
    else $error("foreign address acknowledged");
  a_one_cmd : assert property (state_q == rgb_dim_pkg::ST_ACK_D && scl_fall && !stop_cond && !start_cond
    |=> state_q == rgb_dim_pkg::ST_SKIP ##1 !o_sda_oe)
    else $error("second command byte accepted");
  a_shut_zero : assert property (cmd_taken(rgb_dim_pkg::SEL_SHUTDOWN) |=> cur_q == 5'h00 ##1
    o_mirror_div == 5'h00)
    else $error("shutdown left current on");
  a_peak_direct : assert property (cmd_taken(rgb_dim_pkg::SEL_PEAK) |=> cur_q == $past(payload) && !run_q)
    else $error("peak step not applied directly");
  a_duty_load : assert property (cmd_taken(rgb_dim_pkg::SEL_DUTY2) |=> duty_q[1] == $past(payload))
    else $error("duty not loaded");
  a_tgt_load : assert property (cmd_taken(rgb_dim_pkg::SEL_DN_TGT) |=> dn_tgt_q == $past(payload) && !dir_up_q)
    else $error("downward target not stored");
  a_run_start : assert property (cmd_taken(rgb_dim_pkg::SEL_TIME_RUN) |=> rem_q == $past(diff) &&
    run_q == ($past(diff) != 5'h00))
    else $error("run not started with step count");
  a_step_once : assert property (step_due && !cmd_stb_q |=> (cur_q == $past(cur_q) + 5'h01) ||
    (cur_q == $past(cur_q) - 5'h01))
    else $error("step did not move one position");
  a_hold_between : assert property (run_q && !step_due && !cmd_stb_q |=> cur_q == $past(cur_q))
    else $error("code moved without step time");
  a_ov_trip : assert property (ova_q[1] |=> !o_pump_en)
    else $error("pump not stopped on overvoltage");
  a_top_codes : assert property (cur_q >= 5'h1E |=> o_mirror_div == 5'h01)
    else $error("top codes differ");

endmodule : rgb_dim_core

// File: tb/rgb_i2c_master_model.sv
// Two-wire bus master model that writes command frames to the LED decoder
`timescale 1ns/10ps

module rgb_i2c_master_model
#(
  parameter int P_QTR = 12
)
(
  input  wire logic i_clk_sys,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Bus idles high; the pull-up is modelled by the bench
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic qwait(input int n);
    repeat (n * P_QTR) @(posedge i_clk_sys);
    #1;
  endtask : qwait

  // One full bus clock; line sampled mid high phase
  task automatic pulse(output logic smp);
    qwait(1);
    o_scl = 1'b1;
    qwait(1);
    smp = i_sda_line;
    qwait(1);
    o_scl = 1'b0;
    qwait(1);
  endtask : pulse

  // Sends n bytes, first byte in bits 23..16; acks[0] answers the first byte
  task automatic send(input logic [23:0] frame, input int n, output logic [2:0] acks);
    logic smp;
    acks      = 3'h0;
    o_sda_low = 1'b1;
    qwait(1);
    o_scl = 1'b0;
    for (int b = 0; b < n; b++)
    begin
      for (int k = 7; k >= 0; k--)
      begin
        o_sda_low = ~frame[16 - 8 * b + k];
        pulse(smp);
      end
      o_sda_low = 1'b0;
      pulse(smp);
      acks[b] = ~smp;
    end
    o_sda_low = 1'b1;
    qwait(1);
    o_scl = 1'b1;
    qwait(1);
    o_sda_low = 1'b0;
    qwait(2);
  endtask : send
endmodule : rgb_i2c_master_model

// File: tb/tb_rgb_led_i2c_command_dimming.sv
// Self-checking bench for the LED command decoder and dimming engine
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module tb_rgb_led_i2c_command_dimming;
  // Short step unit keeps each dimming step to a few hundred cycles
  localparam int UNIT = 4;
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sda_low;
  logic       sda_line;
  logic       sda_drv;
  logic       sda_oe;
  logic       ov_above;
  logic       ov_below;
  logic       pump_en;
  logic [2:0] led_on;
  logic [4:0] code;
  logic [4:0] div;
  logic       busy;
  int         fail_count;
  int         tests_run;

  assign sda_line = ~(sda_low | (sda_oe & ~sda_drv));

  rgb_dim_core #(.P_UNIT_TICKS(UNIT)) dut
  (
    .i_clk_sys      (clk),
    .i_resetn       (resetn),
    .i_scl          (scl),
    .i_sda          (sda_line),
    .o_sda          (sda_drv),
    .o_sda_oe       (sda_oe),
    .i_ov_above     (ov_above),
    .i_ov_below     (ov_below),
    .o_pump_en      (pump_en),
    .o_led_on       (led_on),
    .o_current_code (code),
    .o_mirror_div   (div),
    .o_dim_busy     (busy)
  );

  rgb_i2c_master_model m
  (
    .i_clk_sys  (clk),
    .i_sda_line (sda_line),
    .o_scl      (scl),
    .o_sda_low  (sda_low)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic cmd(input logic [2:0] sel, input logic [4:0] pay);
    logic [2:0] acks;
    m.send({8'h72, sel, pay, 8'h00}, 2, acks);
    `CHK(acks[1:0], 2'h3);
    repeat (4) step();
  endtask : cmd

  function automatic logic [4:0] exp_div(input logic [4:0] c);
    if (c == 5'h00)
      return 5'h00;
    if (c >= 5'h1E)
      return 5'h01;
    return 5'h1F - c;
  endfunction : exp_div

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    repeat (20) step();
    `CHK({sda_oe, pump_en, led_on, code, div, busy}, 16'h4000);
    resetn = 1'b1;
    repeat (4) step();
    $display("test reset done");
  endtask : t_reset

  task automatic t_address;
    logic [2:0] acks;
    cmd(3'h1, 5'h07);
    m.send({8'h74, 8'h3C, 8'h00}, 2, acks);
    `CHK(acks[1:0], 2'h0);
    m.send({8'h73, 8'h3C, 8'h00}, 2, acks);
    `CHK(acks[1:0], 2'h0);
    repeat (4) step();
    `CHK(code, 5'h07);
    m.send({8'h72, 8'h25, 8'h3C}, 3, acks);
    `CHK(acks, 3'h3);
    repeat (4) step();
    `CHK(code, 5'h05);
    $display("test address done");
  endtask : t_address

  task automatic t_peak;
    logic [4:0] tbl [6] = '{5'h00, 5'h01, 5'h0F, 5'h1D, 5'h1E, 5'h1F};
    for (int i = 0; i < 6; i++)
    begin
      cmd(3'h1, tbl[i]);
      `CHK({busy, code}, {1'b0, tbl[i]});
      `CHK(div, exp_div(tbl[i]));
    end
    cmd(3'h1, 5'h0A);
    cmd(3'h0, 5'h1F);
    `CHK({code, div}, 10'h000);
    $display("test peak done");
  endtask : t_peak

  task automatic t_duty;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] c2;
    cmd(3'h2, 5'h00);
    cmd(3'h3, 5'h1F);
    cmd(3'h4, 5'h10);
    {c0, c1, c2} = 48'h0;
    // One whole modulation frame of 32 phases at 300 cycles each
    repeat (9600)
    begin
      step();
      c0 = c0 + 16'(led_on[0]);
      c1 = c1 + 16'(led_on[1]);
      c2 = c2 + 16'(led_on[2]);
    end
    `CHK(c0, 16'h0000);
    `CHK(c1, 16'h2580);
    `CHK(c2, 16'h12C0);
    $display("test duty done");
  endtask : t_duty

  task automatic t_dim(input logic [4:0] start, input logic [2:0] tsel, input logic [4:0] tgt,
                       input logic [4:0] tim, input int steps);
    int         gap;
    int         seen;
    logic [4:0] prev;
    cmd(3'h1, start);
    cmd(tsel, tgt);
    cmd(3'h7, tim);
    `CHK({busy, code}, {1'b1, start});
    prev = start;
    seen = 0;
    gap  = 0;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
    begin
      step();
      gap++;
      if (code !== prev)
      begin
        `CHK(code, (tsel == 3'h5) ? prev + 5'h01 : prev - 5'h01);
        if (seen > 0)
          `CHK(gap, UNIT * 20 * int'(tim));
        seen++;
        gap  = 0;
        prev = code;
      end
    end
    `CHK(seen, steps);
    repeat (UNIT * 20 * int'(tim) + 20) step();
    `CHK({busy, code}, {1'b0, tgt});
    $display("test dimming done");
  endtask : t_dim

  task automatic t_pump;
    ov_above = 1'b1;
    repeat (5) step();
    `CHK(pump_en, 1'b0);
    ov_above = 1'b0;
    repeat (5) step();
    `CHK(pump_en, 1'b0);
    ov_below = 1'b1;
    repeat (5) step();
    `CHK(pump_en, 1'b1);
    ov_above = 1'b1;
    repeat (5) step();
    `CHK(pump_en, 1'b0);
    ov_above = 1'b0;
    repeat (5) step();
    `CHK(pump_en, 1'b1);
    $display("test pump done");
  endtask : t_pump

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    resetn     = 1'b0;
    ov_above   = 1'b0;
    ov_below   = 1'b0;
    fail_count = 0;
    tests_run  = 0;
    t_reset();
    t_address();
    t_peak();
    t_duty();
    t_dim(5'h05, 3'h5, 5'h08, 5'h02, 3);
    t_dim(5'h08, 3'h6, 5'h02, 5'h03, 6);
    t_pump();
    test_done();
  end

  // Whole run needs about 32000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : tb_rgb_led_i2c_command_dimming
